// >>> bfdl_pkg.sv
/*
  constants for the breaker failure decision logic: register map,
  field positions, reset values, setting ranges and the tick period.
  assumes a 10 MHz core clock and a 32-bit APB register bus.
*/
package bfdl_pkg;

  // clock and millisecond tick
  localparam int CLK_PERIOD_NS  = 100;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_RETRIP  = 8'h04;
  localparam logic [7:0] OFS_BACKUP  = 8'h08;
  localparam logic [7:0] OFS_PULSE   = 8'h0c;
  localparam logic [7:0] OFS_THRESH  = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_MASK    = 8'h18;
  localparam logic [7:0] OFS_STATE   = 8'h1c;

  // control and threshold field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_RETRIP    = 2;
  localparam int CTRL_PERPHASE  = 3;
  localparam int CTRL_SYNCCLR   = 4;
  localparam int THRESH_RES_LSB = 8;

  // operation mode codes
  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [1:0] MODE_CURRENT = 2'h1;
  localparam logic [1:0] MODE_CONTACT = 2'h2;
  localparam logic [1:0] MODE_BOTH    = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // setting ranges (ms, percent) and values after reset
  localparam logic [15:0] RETRIP_MAX  = 16'h03e8;
  localparam logic [15:0] BACKUP_MIN  = 16'h0064;
  localparam logic [15:0] BACKUP_MAX  = 16'hea60;
  localparam logic [15:0] PULSE_MAX   = 16'hea60;
  localparam logic [7:0]  PH_MIN      = 8'h14;
  localparam logic [7:0]  PH_MAX      = 8'hc8;
  localparam logic [7:0]  RES_MIN     = 8'h0a;
  localparam logic [7:0]  RES_MAX     = 8'hc8;
  localparam logic [15:0] RETRIP_RST  = 16'h0064;
  localparam logic [15:0] BACKUP_RST  = 16'h03e8;
  localparam logic [15:0] PULSE_RST   = 16'h0064;
  localparam logic [7:0]  PH_RST      = 8'h1e;
  localparam logic [7:0]  RES_RST     = 8'h14;

endpackage : bfdl_pkg

// >>> bfdl_chan.sv
/*
  one breaker failure channel: backup and retrip timers, trip latches
  and minimum pulse stretch.  assumes a one-cycle millisecond tick and
  a combined failure condition prepared by the caller.
*/
`timescale 1ns/1ps
module bfdl_chan (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // timing
  input  wire logic        tick,
  input  wire logic [15:0] rtDly,
  input  wire logic [15:0] bkDly,
  input  wire logic [15:0] pulseDly,
  // control
  input  wire logic        clear,
  input  wire logic        retripEn,
  input  wire logic        start,
  input  wire logic        fail,
  // results
  output logic             backupTrip,
  output logic             retrip,
  output logic             running
);

  typedef struct packed {
    logic        startPrev;
    logic        running;
    logic [15:0] bkCnt;
    logic [15:0] rtCnt;
    logic        bkDone;
    logic        rtDone;
    logic        bkTrip;
    logic        rtTrip;
    logic [15:0] bkPulse;
    logic [15:0] rtPulse;
  } bfdl_chan_s;

  bfdl_chan_s s;
  bfdl_chan_s next_s;
  logic       bkRel;
  logic       rtRel;

  always_comb begin
    next_s = s;
    next_s.startPrev = start;
    bkRel = s.bkTrip && s.bkPulse >= pulseDly && (!start || !fail);
    rtRel = s.rtTrip && s.rtPulse >= pulseDly && (!start || !fail);
    if (clear) begin
      next_s = '0;
      next_s.startPrev = start;
    end else begin
      if (start && !s.startPrev) begin
        next_s.running = 1'b1;
        next_s.bkCnt = '0;
        next_s.rtCnt = '0;
        next_s.bkDone = 1'b0;
        next_s.rtDone = 1'b0;
      end else if (s.running && (!start || !fail)) begin
        next_s.running = 1'b0;
      end else if (s.running) begin
        if (tick && s.bkCnt < bkDly)
          next_s.bkCnt = s.bkCnt + 16'h0001;
        if (tick && s.rtCnt < rtDly)
          next_s.rtCnt = s.rtCnt + 16'h0001;
        if (!s.bkDone && s.bkCnt >= bkDly) begin
          next_s.bkDone = 1'b1;
          next_s.bkTrip = 1'b1;
          next_s.bkPulse = '0;
        end
        if (retripEn && !s.rtDone && s.rtCnt >= rtDly) begin
          next_s.rtDone = 1'b1;
          next_s.rtTrip = 1'b1;
          next_s.rtPulse = '0;
        end
      end
      if (s.bkTrip && tick && s.bkPulse < pulseDly)
        next_s.bkPulse = s.bkPulse + 16'h0001;
      if (s.rtTrip && tick && s.rtPulse < pulseDly)
        next_s.rtPulse = s.rtPulse + 16'h0001;
      if (bkRel)
        next_s.bkTrip = 1'b0;
      if (rtRel)
        next_s.rtTrip = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  assign backupTrip = s.bkTrip;
  assign retrip     = s.rtTrip;
  assign running    = s.running;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_chan_backup_at_delay;
    $rose(s.bkTrip) |-> $past(s.running) && $past(s.bkCnt) >= $past(bkDly);
  endproperty
  a_chan_backup_at_delay : assert property (p_chan_backup_at_delay)
    else $error("backup trip before its delay ran out");

  property p_chan_clear;
    clear |=> !s.bkTrip && !s.rtTrip && !s.running;
  endproperty
  a_chan_clear : assert property (p_chan_clear)
    else $error("clear did not drop trips and timers");

  property p_chan_pulse_min;
    $fell(s.bkTrip) && !$past(clear) |-> $past(s.bkPulse) >= $past(pulseDly);
  endproperty
  a_chan_pulse_min : assert property (p_chan_pulse_min)
    else $error("backup trip pulse shorter than setting");

  property p_chan_retrip_en;
    $rose(s.rtTrip) |-> $past(retripEn) && $past(s.rtCnt) >= $past(rtDly);
  endproperty
  a_chan_retrip_en : assert property (p_chan_retrip_en)
    else $error("retrip without enable or before delay");

  property p_chan_start_edge;
    !clear && start && !s.startPrev |=> s.running && s.bkCnt == 16'h0000;
  endproperty
  a_chan_start_edge : assert property (p_chan_start_edge)
    else $error("start edge did not launch timers");

  c_chan_backup : cover property ($rose(s.bkTrip));

endmodule : bfdl_chan

// >>> bfdl_top.sv
/*
  breaker failure decision logic with APB register access.
  assumes start, contact, block and current-flag inputs come from
  logic on core_clk; current comparators sit upstream and read the
  threshold outputs.
*/
// Notes on behaviour
// - each start rising edge launches backup and retrip timers, per phase
// - supervision follows mode: off, current, contact or both
// - current mode judges only current flags, ignores breaker contacts
// - contact mode judges only breaker-closed inputs, ignores currents
// - both mode resets only when currents low and breaker open
// - mode off gives no backup or retrip outputs
// - backup trip when delay expires and fault still present
// - every trip output holds at least the pulse duration unless block, sync clear, mode off or, for retrip, common variant drops it
// - retrip only in per-phase variant with retrip enabled
// - retrip at retrip delay in phases whose timer runs
// - block input inhibits the whole function
// - common variant uses common start, contact, drives only backup
// - retrip 0-1000, backup 100-60000, pulse 0-60000 ms settings
// - phase threshold 20-200 percent, residual 10-200 percent
// - one backup trip output plus three phase retrip outputs
`timescale 1ns/1ps
module bfdl_top #(
  parameter int TICK_CYCLES = bfdl_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // start requests
  input  wire logic        common_start_in,
  input  wire logic        start_phase1_in,
  input  wire logic        start_phase2_in,
  input  wire logic        start_phase3_in,
  // breaker contacts and block
  input  wire logic        breaker_closed_in,
  input  wire logic        breaker_closed_phase1_in,
  input  wire logic        breaker_closed_phase2_in,
  input  wire logic        breaker_closed_phase3_in,
  input  wire logic        function_block_in,
  // current flags from upstream comparators
  input  wire logic [2:0]  phaseOver,
  input  wire logic        residual_start_in,
  // threshold settings to the comparators
  output logic [7:0]       phaseThreshold,
  output logic [7:0]       residualThreshold,
  // trip commands and interrupt
  output logic             backup_trip_out,
  output logic             retrip_phase1_out,
  output logic             retrip_phase2_out,
  output logic             retrip_phase3_out,
  output logic             irq
);

  typedef struct packed {
    logic [15:0] tickCnt;
    logic        tick;
    logic [1:0]  mode;
    logic        retripEn;
    logic        perPhase;
    logic        syncClr;
    logic [15:0] rtDly;
    logic [15:0] bkDly;
    logic [15:0] pulseDly;
    logic [7:0]  phThr;
    logic [7:0]  resThr;
    logic [3:0]  status;
    logic [3:0]  mask;
    logic [31:0] rdata;
    logic        err;
    logic        backup;
    logic [2:0]  retrip;
  } bfdl_top_s;

  bfdl_top_s s;
  bfdl_top_s next_s;

  logic [2:0]  startVec;
  logic [2:0]  closedVec;
  logic [2:0]  failVec;
  logic [2:0]  chanBackup;
  logic [2:0]  chanRetrip;
  logic [2:0]  chanRunning;
  logic        anyCurrent;
  logic        clearAll;
  logic        chanRetripEn;
  logic        wrEn;
  logic        rdEn;
  logic        mapped;
  logic [3:0]  events;
  logic [31:0] rdMux;

  ////////////////////////////////////////////////////////////////////////
  // settings clamp into their ranges so software cannot set a backup
  // delay below the documented floor
  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (v < lo)
      r = lo;
    else if (v > hi)
      r = hi;
    return r;
  endfunction : clamp16

  function automatic logic [7:0] clamp8(input logic [7:0] v,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
    logic [7:0] r;
    r = v;
    if (v < lo)
      r = lo;
    else if (v > hi)
      r = hi;
    return r;
  endfunction : clamp8

  ////////////////////////////////////////////////////////////////////////
  // channel inputs
  always_comb begin
    anyCurrent = |phaseOver || residual_start_in;
    clearAll = function_block_in || s.syncClr
               || s.mode == bfdl_pkg::MODE_OFF;
    chanRetripEn = s.retripEn && s.perPhase;
    if (s.perPhase) begin
      startVec  = {start_phase3_in, start_phase2_in, start_phase1_in};
      closedVec = {breaker_closed_phase3_in, breaker_closed_phase2_in,
                   breaker_closed_phase1_in};
    end else begin
      startVec  = {2'b00, common_start_in};
      closedVec = {2'b00, breaker_closed_in};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_chan
      logic curFail;
      // common variant watches all phase flags on its single channel
      assign curFail = s.perPhase ? (phaseOver[g] || residual_start_in)
                                  : anyCurrent;
      always_comb begin
        unique case (s.mode)
          bfdl_pkg::MODE_CURRENT: failVec[g] = curFail;
          bfdl_pkg::MODE_CONTACT: failVec[g] = closedVec[g];
          bfdl_pkg::MODE_BOTH:    failVec[g] = curFail
                                               || closedVec[g];
          default:                failVec[g] = 1'b0;
        endcase
      end
      bfdl_chan u_chan (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .tick       (s.tick),
        .rtDly      (s.rtDly),
        .bkDly      (s.bkDly),
        .pulseDly   (s.pulseDly),
        .clear      (clearAll),
        .retripEn   (chanRetripEn),
        .start      (startVec[g]),
        .fail       (failVec[g]),
        .backupTrip (chanBackup[g]),
        .retrip     (chanRetrip[g]),
        .running    (chanRunning[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // register decode
  always_comb begin
    wrEn = psel && penable && pwrite;
    rdEn = psel && !penable && !pwrite;
    mapped = 1'b1;
    rdMux = 32'h0000_0000;
    unique case (paddr)
      bfdl_pkg::OFS_CTRL:   rdMux = {27'h0, 1'b0, s.perPhase, s.retripEn,
                                     s.mode};
      bfdl_pkg::OFS_RETRIP: rdMux = {16'h0, s.rtDly};
      bfdl_pkg::OFS_BACKUP: rdMux = {16'h0, s.bkDly};
      bfdl_pkg::OFS_PULSE:  rdMux = {16'h0, s.pulseDly};
      bfdl_pkg::OFS_THRESH: rdMux = {16'h0, s.resThr, s.phThr};
      bfdl_pkg::OFS_STATUS: rdMux = {28'h0, s.status};
      bfdl_pkg::OFS_MASK:   rdMux = {28'h0, s.mask};
      bfdl_pkg::OFS_STATE:  rdMux = {21'h0, chanRunning, 4'h0, s.retrip,
                                     s.backup};
      default:              mapped = 1'b0;
    endcase
    events = {chanRetrip & ~s.retrip & {3{s.perPhase}},
              (|chanBackup) & ~s.backup};
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_s = s;
    // millisecond tick
    if (s.tickCnt >= 16'(TICK_CYCLES - 1)) begin
      next_s.tickCnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.tickCnt = s.tickCnt + 16'h0001;
      next_s.tick = 1'b0;
    end
    next_s.syncClr = 1'b0;
    if (rdEn) begin
      next_s.rdata = mapped ? rdMux : 32'h0000_0000;
      next_s.err = !mapped;
    end else if (psel && !penable) begin
      next_s.err = !mapped;
    end
    if (wrEn && mapped) begin
      unique case (paddr)
        bfdl_pkg::OFS_CTRL: begin
          next_s.mode = pwdata[bfdl_pkg::CTRL_MODE_LSB +: 2];
          next_s.retripEn = pwdata[bfdl_pkg::CTRL_RETRIP];
          next_s.perPhase = pwdata[bfdl_pkg::CTRL_PERPHASE];
          next_s.syncClr = pwdata[bfdl_pkg::CTRL_SYNCCLR];
        end
        bfdl_pkg::OFS_RETRIP:
          next_s.rtDly = clamp16(pwdata[15:0], 16'h0000,
                                 bfdl_pkg::RETRIP_MAX);
        bfdl_pkg::OFS_BACKUP:
          next_s.bkDly = clamp16(pwdata[15:0], bfdl_pkg::BACKUP_MIN,
                                 bfdl_pkg::BACKUP_MAX);
        bfdl_pkg::OFS_PULSE:
          next_s.pulseDly = clamp16(pwdata[15:0], 16'h0000,
                                    bfdl_pkg::PULSE_MAX);
        bfdl_pkg::OFS_THRESH: begin
          next_s.phThr = clamp8(pwdata[7:0], bfdl_pkg::PH_MIN,
                                bfdl_pkg::PH_MAX);
          next_s.resThr = clamp8(pwdata[bfdl_pkg::THRESH_RES_LSB +: 8],
                                 bfdl_pkg::RES_MIN,
                                 bfdl_pkg::RES_MAX);
        end
        bfdl_pkg::OFS_STATUS: next_s.status = s.status & ~pwdata[3:0];
        bfdl_pkg::OFS_MASK:   next_s.mask = pwdata[3:0];
        default: ;
      endcase
    end
    // set wins over a same-cycle write-one clear
    next_s.status = next_s.status | events;
    next_s.backup = |chanBackup;
    // common variant never shows a retrip, not even one left from per-phase
    next_s.retrip = chanRetrip & {3{s.perPhase}};
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.rtDly <= bfdl_pkg::RETRIP_RST;
      s.bkDly <= bfdl_pkg::BACKUP_RST;
      s.pulseDly <= bfdl_pkg::PULSE_RST;
      s.phThr <= bfdl_pkg::PH_RST;
      s.resThr <= bfdl_pkg::RES_RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs; trips lag channel latches by one cycle
  assign prdata            = s.rdata;
  assign pready            = 1'b1;
  assign pslverr           = s.err && psel && penable;
  assign phaseThreshold    = s.phThr;
  assign residualThreshold = s.resThr;
  assign backup_trip_out   = s.backup;
  assign retrip_phase1_out = s.retrip[0];
  assign retrip_phase2_out = s.retrip[1];
  assign retrip_phase3_out = s.retrip[2];
  assign irq               = |(s.status & s.mask);

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // channel clear takes one cycle, the output register one more
  property p_off_no_trip;
    (s.mode == bfdl_pkg::MODE_OFF) [*3] |-> !backup_trip_out
                                            && !(|s.retrip);
  endproperty
  a_off_no_trip : assert property (p_off_no_trip)
    else $error("trip output while mode is off");

  property p_block_no_trip;
    function_block_in [*3] |-> !backup_trip_out && s.retrip == 3'b000;
  endproperty
  a_block_no_trip : assert property (p_block_no_trip)
    else $error("trip output while blocked");

  property p_common_no_retrip;
    !s.perPhase [*2] |-> s.retrip == 3'b000;
  endproperty
  a_common_no_retrip : assert property (p_common_no_retrip)
    else $error("retrip in common-phase variant");

  property p_backup_follows;
    |chanBackup |=> backup_trip_out;
  endproperty
  a_backup_follows : assert property (p_backup_follows)
    else $error("backup output missed channel trip");

  property p_ranges;
    s.bkDly >= bfdl_pkg::BACKUP_MIN && s.bkDly <= bfdl_pkg::BACKUP_MAX
      && s.rtDly <= bfdl_pkg::RETRIP_MAX && s.phThr >= bfdl_pkg::PH_MIN
      && s.resThr >= bfdl_pkg::RES_MIN;
  endproperty
  a_ranges : assert property (p_ranges)
    else $error("setting outside its range");

  property p_tick_period;
    s.tick |=> !s.tick;
  endproperty
  a_tick_period : assert property (p_tick_period)
    else $error("tick lasted more than one cycle");

  property p_event_sticky;
    $rose(backup_trip_out) |=> s.status[0];
  endproperty
  a_event_sticky : assert property (p_event_sticky)
    else $error("backup event not recorded");

  c_backup_trip  : cover property ($rose(backup_trip_out));
  c_retrip_phase : cover property ($rose(retrip_phase2_out));
  c_block_abort  : cover property (chanRunning[0] ##1 function_block_in);
  c_irq          : cover property ($rose(irq));

endmodule : bfdl_top

// >>> bfdl_partner.sv
/*
  far-side model: protection start requests and a breaker that opens
  OPEN_CYCLES after its start unless the bench holds it stuck.
  assumes the bench drives fault and stuck controls after a clock edge.
*/
`timescale 1ns/1ps
module bfdl_partner #(
  parameter int OPEN_CYCLES = 50
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // scenario controls
  input  wire logic [2:0] fault,
  input  wire logic [2:0] stuckCur,
  input  wire logic [2:0] stuckCon,
  input  wire logic       perPh,
  // start requests
  output logic            common_start_in,
  output logic [2:0]      startPh,
  // breaker contacts and current flags
  output logic            breaker_closed_in,
  output logic [2:0]      closedPh,
  output logic [2:0]      phaseOver,
  output logic            residual_start_in
);
  logic [2:0][7:0] openCnt;
  logic [2:0]      opened;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      openCnt <= '0;
      opened  <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!fault[i]) begin
          openCnt[i] <= 8'h00;
          opened[i]  <= 1'b0;
        end else if (openCnt[i] == 8'(OPEN_CYCLES)) begin
          opened[i] <= 1'b1;
        end else begin
          openCnt[i] <= openCnt[i] + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // only one style of start is driven at a time
  assign startPh           = perPh ? fault : 3'h0;
  assign common_start_in   = !perPh && (fault != 3'h0);
  assign closedPh          = ~opened | stuckCon;
  assign breaker_closed_in = (fault != 3'h0) ? |(fault & closedPh)
                                             : 1'b1;
  // stuck current models a flashover after the poles part
  assign phaseOver         = stuckCur | (fault & ~opened);
  assign residual_start_in = |phaseOver;
endmodule : bfdl_partner

// >>> bfdl_testbench.sv
/*
  self-checking bench: register map, then breaker failure runs.
  assumes bfdl_top with a 10-cycle tick and the bfdl_partner model.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin numErrors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic        blk, pp, ccs, cc, res, bk, irq, err;
  logic [7:0]  paddr, phT, resT;
  logic [31:0] pwdata, prdata, rd, v;
  logic [2:0]  fault, sCur, sCon, sph, cph, over, rt;
  logic [31:0] seed = 32'h8d5e;
  int          numErrors = 0;
  int          checked = 0;
  int          cyc = 0;
  localparam logic [31:0] RV [8] = '{0, 32'h64, 32'h3e8, 32'h64, 32'h141e,
                                     0, 0, 0};

  bfdl_top #(.TICK_CYCLES(10)) dut (.core_clk(core_clk), .rst_b(rst_b),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .common_start_in(ccs), .start_phase1_in(sph[0]),
    .start_phase2_in(sph[1]), .start_phase3_in(sph[2]),
    .breaker_closed_in(cc), .breaker_closed_phase1_in(cph[0]),
    .breaker_closed_phase2_in(cph[1]), .breaker_closed_phase3_in(cph[2]),
    .function_block_in(blk), .phaseOver(over), .residual_start_in(res),
    .phaseThreshold(phT), .residualThreshold(resT), .backup_trip_out(bk),
    .retrip_phase1_out(rt[0]), .retrip_phase2_out(rt[1]),
    .retrip_phase3_out(rt[2]), .irq(irq));
  bfdl_partner u_far (.core_clk(core_clk), .rst_b(rst_b), .fault(fault),
    .stuckCur(sCur), .stuckCon(sCon), .perPh(pp), .common_start_in(ccs),
    .startPh(sph), .breaker_closed_in(cc), .closedPh(cph),
    .phaseOver(over), .residual_start_in(res));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic exp_fail(logic [1:0] m, logic c, logic k);
    case (m)
      bfdl_pkg::MODE_CURRENT: return c;
      bfdl_pkg::MODE_CONTACT: return k;
      bfdl_pkg::MODE_BOTH:    return c | k;
      default:                return 1'b0;
    endcase
  endfunction : exp_fail

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  // ab: 0 plain, 1 block held, 2 block at trip, 3 sync clear at trip
  task automatic run(input logic [1:0] m, input logic p, input logic r,
                     input logic c, input logic k, input int ab);
    int ph, rtd, tB, tF, tR, n;
    logic [3:0] msk, st;
    logic eB, eR, oth;
    ph = int'(xs() % 3);
    rtd = 10 + int'(xs() % 30);
    msk = 4'(xs());
    tB = -1;
    tF = -1;
    tR = -1;
    oth = 1'b0;
    eB = exp_fail(m, c, k) && ab != 1;
    eR = eB && p && r;
    pp <= p;
    apb(1, bfdl_pkg::OFS_RETRIP, 32'(rtd));
    apb(1, bfdl_pkg::OFS_BACKUP, 32'h64);
    apb(1, bfdl_pkg::OFS_PULSE, 32'h1e);
    apb(1, bfdl_pkg::OFS_MASK, {28'h0, msk});
    apb(1, bfdl_pkg::OFS_CTRL, {28'h0, p, r, m});
    blk <= (ab == 1);
    sCur <= c ? 3'(1 << ph) : 3'h0;
    sCon <= k ? 3'(1 << ph) : 3'h0;
    fault <= 3'(1 << ph);
    for (n = 0; n < 1400 && !(ab == 3 && tB >= 0); n++) begin
      @(posedge core_clk);
      if (bk === 1'b1 && tB < 0) begin
        tB = n;
        fault <= 3'h0;
        blk <= (ab == 2);
      end
      if (bk === 1'b0 && tB >= 0 && tF < 0) tF = n;
      if (rt[ph] === 1'b1 && tR < 0) tR = n;
      if ((rt & ~3'(1 << ph)) !== 3'h0) oth = 1'b1;
    end
    if (ab == 3) begin
      apb(1, bfdl_pkg::OFS_CTRL, {27'h0, 1'b1, p, r, m});
      // channel clears one edge after the pulse, the output one edge later
      repeat (2) @(posedge core_clk);
      `CHK(bk, 1'b0)
    end
    `CHK(tB >= 0, eB)
    if (eB) `CHK(tB >= 990 && tB <= 1020, 1'b1)
    if (eB && ab == 0) `CHK(tF >= 0 && tF - tB >= 290, 1'b1)
    if (eB && ab == 2) `CHK(tF >= 0 && tF - tB <= 4, 1'b1)
    `CHK(tR >= 0, eR)
    if (eR) `CHK(tR >= rtd * 10 - 10 && tR <= rtd * 10 + 20, 1'b1)
    `CHK(oth, 1'b0)
    st = {eR ? 3'(1 << ph) : 3'h0, eB};
    apb(0, bfdl_pkg::OFS_STATUS, 0);
    `CHK(rd, {28'h0, st})
    `CHK(irq, |(st & msk))
    apb(1, bfdl_pkg::OFS_STATUS, 32'hf);
    `CHK(irq, 1'b0)
    fault <= 3'h0;
    sCur <= 3'h0;
    sCon <= 3'h0;
    blk <= 1'b0;
    repeat (40) @(posedge core_clk);
    $display("run done mode %0d perphase %0d abort %0d", m, p, ab);
  endtask : run

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // runs need about 19000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      numErrors++;
      finish_test();
    end
  end

  initial begin
    {rst_b, psel, penable, pwrite, blk, pp} = '0;
    {paddr, pwdata, fault, sCur, sCon} = '0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      apb(0, 8'(i * 4), 0);
      `CHK(rd, RV[i])
    end
    apb(0, 8'h20, 0);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(1, bfdl_pkg::OFS_STATE, 32'hffff);
    apb(0, bfdl_pkg::OFS_STATE, 0);
    `CHK(rd, 32'h0)
    apb(1, bfdl_pkg::OFS_BACKUP, 32'h32);
    apb(0, bfdl_pkg::OFS_BACKUP, 0);
    `CHK(rd, 32'h64)
    apb(1, bfdl_pkg::OFS_RETRIP, 32'hffff);
    apb(0, bfdl_pkg::OFS_RETRIP, 0);
    `CHK(rd, 32'h3e8)
    v = 32'(8'(20 + xs() % 181));
    apb(1, bfdl_pkg::OFS_THRESH, v);
    `CHK({resT, phT}, {8'h0a, v[7:0]})
    apb(1, bfdl_pkg::OFS_THRESH, 32'hffff);
    `CHK({resT, phT}, 16'hc8c8)
    $display("register test done");
    // all modes, each with only current or only contact stuck
    for (int i = 0; i < 8; i++) run(2'(i >> 1), 0, 0, ~i[0], i[0], 0);
    run(bfdl_pkg::MODE_BOTH, 1, 1, 1, 1, 0);
    run(bfdl_pkg::MODE_CURRENT, 1, 0, 1, 0, 0);
    run(bfdl_pkg::MODE_CURRENT, 1, 1, 1, 0, 1);
    run(bfdl_pkg::MODE_CURRENT, 0, 0, 1, 0, 2);
    run(bfdl_pkg::MODE_CONTACT, 1, 1, 0, 1, 3);
    finish_test();
  end
endmodule : testbench
